// [dv/pwrc_regbank_assertions.sv]
`timescale 1ns/100ps
// ****************************************************************
// port checks for the power control bank
// ****************************************************************
module pwrc_regbank_assertions
  import pwrc_pkg::*;
#(
  parameter int BUTTONS = 3
) (
  // clock and resets
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               systemResetN,
  // register access
  input wire pwrc_req_t          req,
  input wire logic [DATA_W-1:0]  rdData,
  input wire logic               rdValid,
  // state and pins
  input wire logic               userOffActive,
  input wire logic               cutTimerExpired,
  input wire logic [BUTTONS-1:0] buttonPins,
  input wire logic               watchdogInputPin,
  input wire logic               primarySleepPin,
  input wire logic               secondarySleepPin,
  // control out
  input wire pwrc_ctrl_t         ctrl,
  input wire logic               rtcSupplyOutputOn,
  input wire logic               processorSlowClockOn,
  input wire logic               systemResetReq,
  input wire logic               primarySleepActive,
  input wire logic               secondarySleepActive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // read answers of empty and reserved places
  chk_slot_a_zero: assert property (req.rdEn && req.addr == OFF_UNUSED_SLOT_A |=> rdValid && rdData == 24'h0)
    else $error("slot a not zero");
  chk_slot_b_zero: assert property (req.rdEn && req.addr == OFF_UNUSED_SLOT_B |=> rdValid && rdData == 24'h0)
    else $error("slot b not zero");
  chk_ctrl_resv_zero: assert property (req.rdEn && req.addr == OFF_POWER_CONTROL_PRIMARY |=> rdData[18:10] == 9'h0)
    else $error("primary reserved bits set");
  chk_cut_resv_zero: assert property (req.rdEn && req.addr == OFF_POWER_CUT_TIMING |=> rdData[23:16] == 8'h0)
    else $error("cut reserved bits set");
  chk_pin_resv_zero: assert property (req.rdEn && req.addr == OFF_POWER_PIN_RESET_CONFIG |=>
    rdData[21:19] == 3'h0 && rdData[16:15] == 2'h0) else $error("pin reserved bits set");
  // system reset clears only its own fields
  chk_sysrst_clear: assert property (!systemResetN |=> !ctrl.userOffRequest && !ctrl.thermalThresholdSelect
    && !ctrl.watchdogPinResetEnable && ctrl.sleepDelayCtrl == 2'h1) else $error("system reset fields kept");
  // derived outputs and expiry flag clearing
  chk_rtc_supply: assert property (rtcSupplyOutputOn == ctrl.keepRtcDomainOn)
    else $error("rtc supply mismatch");
  chk_proc_clock: assert property (##1 processorSlowClockOn == (ctrl.keepRtcDomainOn | (ctrl.mcuSlowClockEnable
    & (!$past(userOffActive) | ctrl.mcuClockKeepInUserOff)))) else $error("processor clock mismatch");
  chk_reset_req: assert property (##1 systemResetReq == (|($past(buttonPins) & ctrl.buttonResetEnable)
    | (ctrl.watchdogPinResetEnable & !$past(watchdogInputPin)))) else $error("reset request mismatch");
  chk_expiry_clear: assert property (cutTimerExpired ##1 !(req.wrEn && req.addr == OFF_POWER_CONTROL_PRIMARY)
    ##1 (req.rdEn && req.addr == OFF_POWER_CONTROL_PRIMARY) |=> !rdData[9]) else $error("not expired flag kept");
  // supply output follows the written keep-domain bit two edges later
  chk_rtc_follow: assert property (req.wrEn && req.addr == OFF_POWER_CONTROL_PRIMARY |=> ##1
    rtcSupplyOutputOn == $past(req.wrData[POS_KEEP_RTC_DOM], 2)) else $error("rtc supply not following write");
endmodule
bind pwrc_regbank pwrc_regbank_assertions #(.BUTTONS(BUTTONS)) u_chk (.clk(clk), .rst_n(rst_n),
  .systemResetN(systemResetN), .req(req), .rdData(rdData), .rdValid(rdValid), .userOffActive(userOffActive),
  .cutTimerExpired(cutTimerExpired), .buttonPins(buttonPins), .watchdogInputPin(watchdogInputPin),
  .primarySleepPin(primarySleepPin), .secondarySleepPin(secondarySleepPin), .ctrl(ctrl),
  .rtcSupplyOutputOn(rtcSupplyOutputOn), .processorSlowClockOn(processorSlowClockOn),
  .systemResetReq(systemResetReq), .primarySleepActive(primarySleepActive),
  .secondarySleepActive(secondarySleepActive));

// [dv/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  import pwrc_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic        clk, rst_n, systemResetN, rdValid, userOffActive, cutTimerExpired, watchdogInputPin;
  logic        primarySleepPin, secondarySleepPin, rtcOn, clkOn, rstReq, priAct, secAct;
  logic [2:0]  buttonPins;
  logic [23:0] rdData;
  pwrc_req_t   req;
  pwrc_ctrl_t  ctrl;
  int          n_errors, compares, cycles, i, p;
  logic [5:0]  adr [5] = '{OFF_UNUSED_SLOT_A, OFF_UNUSED_SLOT_B, OFF_POWER_CONTROL_PRIMARY,
                           OFF_POWER_CUT_TIMING, OFF_POWER_PIN_RESET_CONFIG};
  logic [23:0] msk [5] = '{24'h0, 24'h0, 24'hf803ff, 24'h00ffff, 24'hc67fff};
  logic [23:0] pat [2] = '{24'ha5a5a5, 24'hffffff};
  pwrc_regbank dut_u (.clk(clk), .rst_n(rst_n), .systemResetN(systemResetN), .req(req), .rdData(rdData),
    .rdValid(rdValid), .userOffActive(userOffActive), .cutTimerExpired(cutTimerExpired), .buttonPins(buttonPins),
    .watchdogInputPin(watchdogInputPin), .primarySleepPin(primarySleepPin), .secondarySleepPin(secondarySleepPin),
    .ctrl(ctrl), .rtcSupplyOutputOn(rtcOn), .processorSlowClockOn(clkOn), .systemResetReq(rstReq),
    .primarySleepActive(priAct), .secondarySleepActive(secAct));
  // ****************************************************************
  // access and compare tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // write, optionally with an expiry event on the same edge
  task automatic wr(input logic [5:0] a, input logic [23:0] d, input logic x);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d};
    cutTimerExpired <= x;
    @(posedge clk);
    req.wrEn <= 1'b0;
    cutTimerExpired <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [23:0] e, input string nm);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 24'h0};
    @(posedge clk);
    req.rdEn <= 1'b0;
    #1;
    chk("rdValid", 24'h1, {23'h0, rdValid});
    chk(nm, e, rdData);
  endtask
  // let a write reach the derived outputs
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_defaults();
    for (i = 0; i < 5; i++) rd(adr[i], i == 2 ? 24'h000040 : (i == 4 ? 24'h400000 : 24'h0), "default");
    $display("test defaults done");
  endtask
  task automatic t_rw();
    for (p = 0; p < 2; p++)
      for (i = 0; i < 5; i++) begin
        wr(adr[i], pat[p], 1'b0);
        rd(adr[i], pat[p] & msk[i], "readback");
      end
    wr(6'h10, 24'hffffff, 1'b0);
    rd(6'h10, 24'h0, "unmapped");
    $display("test read write done");
  endtask
  task automatic t_sysrst();
    @(posedge clk);
    systemResetN <= 1'b0;
    repeat (2) @(posedge clk);
    systemResetN <= 1'b1;
    rd(adr[2], 24'hf802f7, "sys ctrl");
    rd(adr[3], 24'h00ffff, "sys cut");
    rd(adr[4], 24'h466fff, "sys pin");
    chk("ctrl image", 24'h00ffff, {8'h0, ctrl.cutEventLimit, ctrl.cutEventCount, ctrl.cutTimerValue});
    $display("test system reset done");
  endtask
  task automatic t_expire();
    wr(adr[2], 24'h000240, 1'b0);
    rd(adr[2], 24'h000240, "flag set");
    wr(adr[3], 24'h0, 1'b1);
    rd(adr[2], 24'h000040, "flag cleared");
    wr(adr[2], 24'h000240, 1'b1);
    rd(adr[2], 24'h000040, "expiry wins");
    $display("test expiry done");
  endtask
  task automatic t_outs();
    userOffActive <= 1'b1;
    wr(adr[2], 24'h000040, 1'b0);
    settle();
    chk("clk user off", 24'h0, {23'h0, clkOn});
    wr(adr[2], 24'h000060, 1'b0);
    settle();
    chk("clk kept", 24'h1, {23'h0, clkOn});
    wr(adr[2], 24'h000010, 1'b0);
    settle();
    chk("keep domain", 24'h3, {22'h0, rtcOn, clkOn});
    buttonPins <= 3'b010;
    wr(adr[4], 24'h401402, 1'b0);
    settle();
    chk("sleep", 24'h2, {22'h0, priAct, secAct});
    chk("no reset", 24'h0, {23'h0, rstReq});
    buttonPins <= 3'b001;
    settle();
    chk("button reset", 24'h1, {23'h0, rstReq});
    buttonPins <= 3'b000;
    watchdogInputPin <= 1'b0;
    settle();
    chk("watchdog reset", 24'h1, {23'h0, rstReq});
    secondarySleepPin <= 1'b1;
    wr(adr[4], 24'h400800, 1'b0);
    settle();
    chk("sleep inverted", 24'h0, {22'h0, priAct, secAct});
    $display("test outputs done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ****************************************************************
  // clock, timeout and main sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    {rst_n, userOffActive, cutTimerExpired, primarySleepPin, secondarySleepPin, buttonPins} = '0;
    {systemResetN, watchdogInputPin} = 2'b11;
    req = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_defaults();
    t_rw();
    t_sysrst();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_defaults();
    t_expire();
    t_outs();
    conclude();
  end
endmodule

// [include/pwrc_pkg.sv]
// ****************************************************************
// power control register bank constants and carriers
// ****************************************************************
package pwrc_pkg;

  // bus widths
  localparam int ADDR_W = 6;
  localparam int DATA_W = 24;

  // register offsets
  localparam logic [ADDR_W-1:0] OFF_UNUSED_SLOT_A          = 6'h0b;
  localparam logic [ADDR_W-1:0] OFF_UNUSED_SLOT_B          = 6'h0c;
  localparam logic [ADDR_W-1:0] OFF_POWER_CONTROL_PRIMARY  = 6'h0d;
  localparam logic [ADDR_W-1:0] OFF_POWER_CUT_TIMING       = 6'h0e;
  localparam logic [ADDR_W-1:0] OFF_POWER_PIN_RESET_CONFIG = 6'h0f;

  // primary control field positions
  localparam int POS_CUT_FUNC_EN     = 0;
  localparam int POS_CUT_CNT_EN      = 1;
  localparam int POS_WARM_EN         = 2;
  localparam int POS_USER_OFF_REQ    = 3;
  localparam int POS_KEEP_RTC_DOM    = 4;
  localparam int POS_MCU_CLK_KEEP_UO = 5;
  localparam int POS_MCU_CLK_EN      = 6;
  localparam int POS_GLOBAL_RST      = 7;
  localparam int POS_THERMAL_SEL     = 8;
  localparam int POS_CUT_NOT_EXP     = 9;
  localparam int POS_BATT_DET_EN     = 19;
  localparam int POS_CELL_VSEL_LO    = 20;
  localparam int POS_CELL_CHG_EN     = 23;

  // cut timing field positions
  localparam int POS_CUT_TIMER_LO = 0;
  localparam int POS_CUT_COUNT_LO = 8;
  localparam int POS_CUT_LIMIT_LO = 12;

  // pin reset config field positions
  localparam int POS_AUTO_RESTART   = 0;
  localparam int POS_BTN_RST_EN_LO  = 1;
  localparam int POS_BTN_DBNC_LO    = 4;
  localparam int POS_PRI_SLEEP_POL  = 10;
  localparam int POS_SEC_SLEEP_POL  = 11;
  localparam int POS_WDOG_RST_EN    = 12;
  localparam int POS_SERIAL_DRV_LO  = 13;
  localparam int POS_SLOW_CLK_DRV_LO = 17;
  localparam int POS_SLEEP_DLY_LO   = 22;

  // values after reset
  localparam logic       RST_MCU_CLK_EN   = 1'b1;
  localparam logic [1:0] RST_SLEEP_DLY    = 2'h1;
  localparam logic       RST_GLOBAL_RST_A = 1'b0;

  // register request from the serial control interface
  typedef struct packed {
    logic              wrEn;
    logic              rdEn;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
  } pwrc_req_t;

  // control fields as seen by the power logic
  typedef struct packed {
    logic       cutFunctionEnable;
    logic       cutCounterEnable;
    logic       warmStartEnable;
    logic       userOffRequest;
    logic       keepRtcDomainOn;
    logic       mcuClockKeepInUserOff;
    logic       mcuSlowClockEnable;
    logic       globalResetCtrl;
    logic       thermalThresholdSelect;
    logic       batteryDetectEnable;
    logic [2:0] backupCellVoltageSel;
    logic       backupCellChargeEnable;
    logic [7:0] cutTimerValue;
    logic [3:0] cutEventCount;
    logic [3:0] cutEventLimit;
    logic       autoRestartEnable;
    logic [2:0] buttonResetEnable;
    logic [5:0] buttonDebounce;
    logic       watchdogPinResetEnable;
    logic [1:0] serialPortDrive;
    logic [1:0] slowClockDrive;
    logic [1:0] sleepDelayCtrl;
  } pwrc_ctrl_t;

endpackage

// [verilog/pwrc_field.sv]
`timescale 1ns/100ps
// ****************************************************************
// writable field with its own asynchronous reset
// ****************************************************************
module pwrc_field #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstN,
  // write side
  input  wire logic         wrEn,
  input  wire logic [W-1:0] wrData,
  // stored value
  output logic      [W-1:0] q
);

  // refuse a zero width
  if (W < 1) begin : gBadW
    $error("pwrc_field width must be at least one");
  end

  // field storage
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      q <= RST;
    end else if (wrEn) begin
      q <= wrData;
    end
  end

endmodule

// [verilog/pwrc_regbank.sv]
`timescale 1ns/100ps
module pwrc_regbank
  import pwrc_pkg::*;
#(
  parameter logic GLOBAL_RST_DEFAULT = RST_GLOBAL_RST_A,
  parameter int   BUTTONS            = 3
) (
  // clock and resets
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              systemResetN,
  // register access
  input  wire pwrc_req_t         req,
  output logic      [DATA_W-1:0] rdData,
  output logic                   rdValid,
  // power state and events
  input  wire logic              userOffActive,
  input  wire logic              cutTimerExpired,
  // pins
  input  wire logic [BUTTONS-1:0] buttonPins,
  input  wire logic              watchdogInputPin,
  input  wire logic              primarySleepPin,
  input  wire logic              secondarySleepPin,
  // control out
  output pwrc_ctrl_t             ctrl,
  output logic                   rtcSupplyOutputOn,
  output logic                   processorSlowClockOn,
  output logic                   systemResetReq,
  output logic                   primarySleepActive,
  output logic                   secondarySleepActive
);

  // ****************************************************************
  // checks and decode
  // ****************************************************************

  if (BUTTONS != 3) begin : gBadButtons
    $error("pwrc_regbank serves exactly three buttons");
  end

  // address match for a given register
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  logic              wrPrimary;
  logic              wrTiming;
  logic              wrPinCfg;
  logic              sysRstN;
  logic [DATA_W-1:0] wd;

  // write strobes per register; unused slots get none
  assign wrPrimary = req.wrEn && hit(req.addr, OFF_POWER_CONTROL_PRIMARY);
  assign wrTiming  = req.wrEn && hit(req.addr, OFF_POWER_CUT_TIMING);
  assign wrPinCfg  = req.wrEn && hit(req.addr, OFF_POWER_PIN_RESET_CONFIG);
  assign wd        = req.wrData;

  // system reset also fires whenever the RTC reset does
  assign sysRstN = rst_n & systemResetN;

  // ****************************************************************
  // primary control, RTC reset domain
  // ****************************************************************

  logic       cutFunctionEnable_r;
  logic       cutCounterEnable_r;
  logic       warmStartEnable_r;
  logic       keepRtcDomainOn_r;
  logic       mcuClockKeepInUserOff_r;
  logic       mcuSlowClockEnable_r;
  logic       globalResetCtrl_r;
  logic       cutTimerNotExpired_r;
  logic       cutTimerNotExpired_nxt;
  logic       batteryDetectEnable_r;
  logic [2:0] backupCellVoltageSel_r;
  logic       backupCellChargeEnable_r;

  // power cut and warm start enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cutFunctionEnable_r <= 1'b0;
      cutCounterEnable_r  <= 1'b0;
      warmStartEnable_r   <= 1'b0;
    end else if (wrPrimary) begin
      cutFunctionEnable_r <= wd[POS_CUT_FUNC_EN];
      cutCounterEnable_r  <= wd[POS_CUT_CNT_EN];
      warmStartEnable_r   <= wd[POS_WARM_EN];
    end
  end

  // slow clock and rtc domain keep-alive controls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      keepRtcDomainOn_r       <= 1'b0;
      mcuClockKeepInUserOff_r <= 1'b0;
      mcuSlowClockEnable_r    <= RST_MCU_CLK_EN;
    end else if (wrPrimary) begin
      keepRtcDomainOn_r       <= wd[POS_KEEP_RTC_DOM];
      mcuClockKeepInUserOff_r <= wd[POS_MCU_CLK_KEEP_UO];
      mcuSlowClockEnable_r    <= wd[POS_MCU_CLK_EN];
    end
  end

  // global reset control, default depends on variant
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      globalResetCtrl_r <= GLOBAL_RST_DEFAULT;
    end else if (wrPrimary) begin
      globalResetCtrl_r <= wd[POS_GLOBAL_RST];
    end
  end

  // not-expired flag: expiry wins over a same-cycle software set
  always_comb begin
    cutTimerNotExpired_nxt = cutTimerNotExpired_r;
    if (wrPrimary) begin
      cutTimerNotExpired_nxt = wd[POS_CUT_NOT_EXP];
    end
    if (cutTimerExpired) begin
      cutTimerNotExpired_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cutTimerNotExpired_r <= 1'b0;
    end else begin
      cutTimerNotExpired_r <= cutTimerNotExpired_nxt;
    end
  end

  // battery detect and backup cell charger
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      batteryDetectEnable_r    <= 1'b0;
      backupCellVoltageSel_r   <= 3'h0;
      backupCellChargeEnable_r <= 1'b0;
    end else if (wrPrimary) begin
      batteryDetectEnable_r    <= wd[POS_BATT_DET_EN];
      backupCellVoltageSel_r   <= wd[POS_CELL_VSEL_LO +: 3];
      backupCellChargeEnable_r <= wd[POS_CELL_CHG_EN];
    end
  end

  // ****************************************************************
  // system reset domain fields
  // ****************************************************************

  logic       userOffRequest_r;
  logic       thermalThresholdSelect_r;
  logic       watchdogPinResetEnable_r;
  logic [1:0] sleepDelayCtrl_r;

  // user off command
  pwrc_field #(.W(1), .RST(1'b0)) uUserOff (
    .clk    (clk),
    .rstN   (sysRstN),
    .wrEn   (wrPrimary),
    .wrData (wd[POS_USER_OFF_REQ]),
    .q      (userOffRequest_r)
  );

  // thermal threshold select
  pwrc_field #(.W(1), .RST(1'b0)) uThermal (
    .clk    (clk),
    .rstN   (sysRstN),
    .wrEn   (wrPrimary),
    .wrData (wd[POS_THERMAL_SEL]),
    .q      (thermalThresholdSelect_r)
  );

  // watchdog pin reset enable
  pwrc_field #(.W(1), .RST(1'b0)) uWdogEn (
    .clk    (clk),
    .rstN   (sysRstN),
    .wrEn   (wrPinCfg),
    .wrData (wd[POS_WDOG_RST_EN]),
    .q      (watchdogPinResetEnable_r)
  );

  // standby delay control, resets to 01
  pwrc_field #(.W(2), .RST(RST_SLEEP_DLY)) uSleepDly (
    .clk    (clk),
    .rstN   (sysRstN),
    .wrEn   (wrPinCfg),
    .wrData (wd[POS_SLEEP_DLY_LO +: 2]),
    .q      (sleepDelayCtrl_r)
  );

  // ****************************************************************
  // power cut timing
  // ****************************************************************

  logic [7:0] cutTimerValue_r;
  logic [3:0] cutEventCount_r;
  logic [3:0] cutEventLimit_r;

  // timer, count and limit fields
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cutTimerValue_r <= 8'h00;
      cutEventCount_r <= 4'h0;
      cutEventLimit_r <= 4'h0;
    end else if (wrTiming) begin
      cutTimerValue_r <= wd[POS_CUT_TIMER_LO +: 8];
      cutEventCount_r <= wd[POS_CUT_COUNT_LO +: 4];
      cutEventLimit_r <= wd[POS_CUT_LIMIT_LO +: 4];
    end
  end

  // ****************************************************************
  // pin reset configuration, RTC reset domain
  // ****************************************************************

  logic       autoRestartEnable_r;
  logic [2:0] buttonResetEnable_r;
  logic [5:0] buttonDebounce_r;
  logic [1:0] sleepActiveLow_r;
  logic [1:0] serialPortDrive_r;
  logic [1:0] slowClockDrive_r;

  // restart and button reset enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      autoRestartEnable_r <= 1'b0;
      buttonResetEnable_r <= 3'h0;
    end else if (wrPinCfg) begin
      autoRestartEnable_r <= wd[POS_AUTO_RESTART];
      buttonResetEnable_r <= wd[POS_BTN_RST_EN_LO +: 3];
    end
  end

  // debounce selections, two bits per button
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buttonDebounce_r <= 6'h00;
    end else if (wrPinCfg) begin
      buttonDebounce_r <= wd[POS_BTN_DBNC_LO +: 6];
    end
  end

  // standby polarity selections
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleepActiveLow_r <= 2'h0;
    end else if (wrPinCfg) begin
      sleepActiveLow_r[0] <= wd[POS_PRI_SLEEP_POL];
      sleepActiveLow_r[1] <= wd[POS_SEC_SLEEP_POL];
    end
  end

  // output drive settings
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serialPortDrive_r <= 2'h0;
      slowClockDrive_r  <= 2'h0;
    end else if (wrPinCfg) begin
      serialPortDrive_r <= wd[POS_SERIAL_DRV_LO +: 2];
      slowClockDrive_r  <= wd[POS_SLOW_CLK_DRV_LO +: 2];
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************

  logic [DATA_W-1:0] rdData_nxt;

  // assemble the addressed word; reserved and unmapped bits are zero
  always_comb begin
    rdData_nxt = '0;
    if (hit(req.addr, OFF_POWER_CONTROL_PRIMARY)) begin
      rdData_nxt[POS_CUT_FUNC_EN]        = cutFunctionEnable_r;
      rdData_nxt[POS_CUT_CNT_EN]         = cutCounterEnable_r;
      rdData_nxt[POS_WARM_EN]            = warmStartEnable_r;
      rdData_nxt[POS_USER_OFF_REQ]       = userOffRequest_r;
      rdData_nxt[POS_KEEP_RTC_DOM]       = keepRtcDomainOn_r;
      rdData_nxt[POS_MCU_CLK_KEEP_UO]    = mcuClockKeepInUserOff_r;
      rdData_nxt[POS_MCU_CLK_EN]         = mcuSlowClockEnable_r;
      rdData_nxt[POS_GLOBAL_RST]         = globalResetCtrl_r;
      rdData_nxt[POS_THERMAL_SEL]        = thermalThresholdSelect_r;
      rdData_nxt[POS_CUT_NOT_EXP]        = cutTimerNotExpired_r;
      rdData_nxt[POS_BATT_DET_EN]        = batteryDetectEnable_r;
      rdData_nxt[POS_CELL_VSEL_LO +: 3]  = backupCellVoltageSel_r;
      rdData_nxt[POS_CELL_CHG_EN]        = backupCellChargeEnable_r;
    end else if (hit(req.addr, OFF_POWER_CUT_TIMING)) begin
      rdData_nxt[POS_CUT_TIMER_LO +: 8]  = cutTimerValue_r;
      rdData_nxt[POS_CUT_COUNT_LO +: 4]  = cutEventCount_r;
      rdData_nxt[POS_CUT_LIMIT_LO +: 4]  = cutEventLimit_r;
    end else if (hit(req.addr, OFF_POWER_PIN_RESET_CONFIG)) begin
      rdData_nxt[POS_AUTO_RESTART]        = autoRestartEnable_r;
      rdData_nxt[POS_BTN_RST_EN_LO +: 3]  = buttonResetEnable_r;
      rdData_nxt[POS_BTN_DBNC_LO +: 6]    = buttonDebounce_r;
      rdData_nxt[POS_PRI_SLEEP_POL]       = sleepActiveLow_r[0];
      rdData_nxt[POS_SEC_SLEEP_POL]       = sleepActiveLow_r[1];
      rdData_nxt[POS_WDOG_RST_EN]         = watchdogPinResetEnable_r;
      rdData_nxt[POS_SERIAL_DRV_LO +: 2]  = serialPortDrive_r;
      rdData_nxt[POS_SLOW_CLK_DRV_LO +: 2] = slowClockDrive_r;
      rdData_nxt[POS_SLEEP_DLY_LO +: 2]   = sleepDelayCtrl_r;
    end
  end

  // read data held until the next read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData  <= '0;
      rdValid <= 1'b0;
    end else begin
      rdValid <= req.rdEn;
      if (req.rdEn) begin
        rdData <= rdData_nxt;
      end
    end
  end

  // ****************************************************************
  // control outputs
  // ****************************************************************

  logic buttonHit;

  // field image for the power logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= '0;
    end else begin
      ctrl.cutFunctionEnable      <= cutFunctionEnable_r;
      ctrl.cutCounterEnable       <= cutCounterEnable_r;
      ctrl.warmStartEnable        <= warmStartEnable_r;
      ctrl.userOffRequest         <= userOffRequest_r;
      ctrl.keepRtcDomainOn        <= keepRtcDomainOn_r;
      ctrl.mcuClockKeepInUserOff  <= mcuClockKeepInUserOff_r;
      ctrl.mcuSlowClockEnable     <= mcuSlowClockEnable_r;
      ctrl.globalResetCtrl        <= globalResetCtrl_r;
      ctrl.thermalThresholdSelect <= thermalThresholdSelect_r;
      ctrl.batteryDetectEnable    <= batteryDetectEnable_r;
      ctrl.backupCellVoltageSel   <= backupCellVoltageSel_r;
      ctrl.backupCellChargeEnable <= backupCellChargeEnable_r;
      ctrl.cutTimerValue          <= cutTimerValue_r;
      ctrl.cutEventCount          <= cutEventCount_r;
      ctrl.cutEventLimit          <= cutEventLimit_r;
      ctrl.autoRestartEnable      <= autoRestartEnable_r;
      ctrl.buttonResetEnable      <= buttonResetEnable_r;
      ctrl.buttonDebounce         <= buttonDebounce_r;
      ctrl.watchdogPinResetEnable <= watchdogPinResetEnable_r;
      ctrl.serialPortDrive        <= serialPortDrive_r;
      ctrl.slowClockDrive         <= slowClockDrive_r;
      ctrl.sleepDelayCtrl         <= sleepDelayCtrl_r;
    end
  end

  // enabled button pressed (pins high when pressed)
  assign buttonHit = |(buttonPins & buttonResetEnable_r);

  // supply, processor clock and reset request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rtcSupplyOutputOn    <= 1'b0;
      processorSlowClockOn <= 1'b0;
      systemResetReq       <= 1'b0;
    end else begin
      rtcSupplyOutputOn    <= keepRtcDomainOn_r;
      processorSlowClockOn <= keepRtcDomainOn_r ||
                              (mcuSlowClockEnable_r && (!userOffActive || mcuClockKeepInUserOff_r));
      systemResetReq       <= buttonHit || (watchdogPinResetEnable_r && !watchdogInputPin);
    end
  end

  // standby inputs with polarity applied
  pwrc_sleep_pol #(.N(2)) uSleepPol (
    .clk       (clk),
    .rstN      (rst_n),
    .pin       ({secondarySleepPin, primarySleepPin}),
    .activeLow (sleepActiveLow_r),
    .active    ({secondarySleepActive, primarySleepActive})
  );

endmodule

// [verilog/pwrc_sleep_pol.sv]
`timescale 1ns/100ps
// ****************************************************************
// standby input polarity correction
// ****************************************************************
module pwrc_sleep_pol #(
  parameter int N = 2
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstN,
  // raw pins and polarity
  input  wire logic [N-1:0] pin,
  input  wire logic [N-1:0] activeLow,
  // corrected level
  output logic      [N-1:0] active
);

  if (N < 1) begin : gBadN
    $error("pwrc_sleep_pol needs at least one input");
  end

  // one flop per input, inverted when active low is chosen
  for (genvar i = 0; i < N; i++) begin : gPol
    always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
        active[i] <= 1'b0;
      end else begin
        active[i] <= pin[i] ^ activeLow[i];
      end
    end
  end

endmodule
